/* design/irq_prio_arbiter.sv */
`timescale 1ns/100ps
module irq_prio_arbiter #(
  parameter int N = 11
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // per-source requests and levels, index is polling order
  input  wire logic [N-1:0]     req,
  input  wire logic [2*N-1:0]   level,
  // current service level, 0 = none; bit k => level k-1 in service
  input  wire logic [4:0]       in_service,
  // registered result
  output logic                  win_valid_q,
  output logic [3:0]            win_src_q,
  output logic [1:0]            win_level_q
);
  logic [3:0] best_src;
  logic [1:0] best_lvl;
  logic       best_any;
  logic       preempt;
  always_comb
  begin
    best_src = irq_prio_pkg::NO_SRC;
    best_lvl = 2'h0;
    best_any = 1'b0;
    // strict > keeps the earliest source on a tie
    for (int i = 0; i < N; i++)
    begin
      if (req[i] && (!best_any || level[2*i +: 2] > best_lvl))
      begin
        best_any = 1'b1;
        best_lvl = level[2*i +: 2];
        best_src = 4'(i);
      end
    end
  end
  // only a strictly higher level may interrupt the handler in service
  assign preempt = best_any &&
                   (in_service[4:1] >> best_lvl) == 4'h0;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_valid_q <= 1'b0;
      win_src_q   <= irq_prio_pkg::NO_SRC;
      win_level_q <= 2'h0;
    end
    else
    begin
      win_valid_q <= preempt;
      win_src_q   <= preempt ? best_src : irq_prio_pkg::NO_SRC;
      win_level_q <= preempt ? best_lvl : 2'h0;
    end
  end
endmodule

/* design/irq_prio_pkg.sv */
package irq_prio_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_PRIO_HIGH_CORE = 8'hB7;
  localparam logic [7:0] ADDR_PRIO_HIGH_EXT  = 8'hF7;
  localparam logic [7:0] ADDR_PRIO_LOW_EXT   = 8'hF8;
  localparam logic [7:0] ADDR_PRIO_LOW_CORE  = 8'hB8;
  localparam logic [7:0] ADDR_PENDING        = 8'hC0;
  localparam logic [7:0] ADDR_ENABLE         = 8'hC4;
  localparam logic [7:0] ADDR_SERVICE        = 8'hC8;
  localparam logic [7:0] ADDR_BITOP          = 8'hCC;
  // reset values and defined-bit masks
  localparam logic [7:0] CORE_MASK  = 8'h7F;
  localparam logic [7:0] EXT_MASK   = 8'h0F;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  // extended register bit positions
  localparam int POS_SPI     = 3;
  localparam int POS_TIMOVR  = 2;
  localparam int POS_ADC     = 1;
  localparam int POS_CAN     = 0;
  // core register bit positions
  localparam int POS_PCA     = 6;
  localparam int POS_T2      = 5;
  localparam int POS_UART    = 4;
  localparam int POS_T1      = 3;
  localparam int POS_EXT1    = 2;
  localparam int POS_T0      = 1;
  localparam int POS_EXT0    = 0;
  // source count and polling-order indices
  localparam int NUM_SRC     = 11;
  localparam int CORE_SRC    = 7;
  localparam logic [3:0] NO_SRC = 4'hF;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // bit-op command fields: [15] set value, [10:8] bit, [7:0] address
  localparam int BITOP_VAL = 15;
  localparam int BITOP_BIT = 8;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_ACK  = 3'b010,
    ST_DONE = 3'b100
  } bus_state_type;
endpackage

/* design/irq_prio_regs.sv */
// Function
// - extended sources take level msb from ext high, lsb from ext low
// - two-bit level, 00 lowest, 11 highest, ranked by binary value
// - ext bits: spi 3, timer overrun 2, adc 1, can 0 in both
// - core high bits 6..0: pca, timer2, serial, timer1, ext1, timer0, ext0
// - unused upper bits read indeterminate; nothing relies on them; here they read back what was last written
// - ext low resets defined bits to zero and is bit addressable
// - core high resets its seven bits to zero
// - ext high sits at address F7h, resets defined bits to zero
// - higher level preempts; same or lower waits for handler end
// - ties broken by fixed polling order ext0 first, spi last
`timescale 1ns/100ps
module irq_prio_regs #(
  parameter int NUM_SRC = irq_prio_pkg::NUM_SRC
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // avalon-mm slave
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // sources in polling order: ext0,t0,ext1,t1,pca,uart,t2,can,adc,tovr,spi
  input  wire logic [NUM_SRC-1:0] irq_req,
  // processor core: handler entry and return
  input  wire logic             irq_ack,
  input  wire logic             irq_return,
  output logic                  irq_valid,
  output logic [3:0]            irq_src,
  output logic [1:0]            irq_level
);
  irq_prio_pkg::bus_state_type state_q, state_d;
  logic [7:0]  high_core_q, low_core_q, high_ext_q, low_ext_q;
  logic [NUM_SRC-1:0] enable_q;
  logic [4:0]  service_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [2*NUM_SRC-1:0] levels;
  wire         access   = avs_read | avs_write;
  // start marks the edge that takes a request, take the answer cycle
  wire         start    = (state_q == irq_prio_pkg::ST_IDLE) & access;
  wire         take     = (state_q == irq_prio_pkg::ST_ACK);
  wire         wr       = take & avs_write;
  // bit-op command reaches the bit-addressable ext low register
  wire [7:0]   bop_addr = avs_writedata[7:0];
  wire [2:0]   bop_bit  = avs_writedata[irq_prio_pkg::BITOP_BIT +: 3];
  wire         bop_val  = avs_writedata[irq_prio_pkg::BITOP_VAL];
  wire         sel_hc   = avs_address == irq_prio_pkg::ADDR_PRIO_HIGH_CORE;
  wire         sel_he   = avs_address == irq_prio_pkg::ADDR_PRIO_HIGH_EXT;
  wire         sel_le   = avs_address == irq_prio_pkg::ADDR_PRIO_LOW_EXT;
  wire         sel_lc   = avs_address == irq_prio_pkg::ADDR_PRIO_LOW_CORE;
  wire         sel_en   = avs_address == irq_prio_pkg::ADDR_ENABLE;
  wire         sel_pd   = avs_address == irq_prio_pkg::ADDR_PENDING;
  wire         sel_sv   = avs_address == irq_prio_pkg::ADDR_SERVICE;
  wire         sel_bo   = avs_address == irq_prio_pkg::ADDR_BITOP;
  wire         bop_le   = bop_addr == irq_prio_pkg::ADDR_PRIO_LOW_EXT;
  wire [7:0]   wbyte    = avs_writedata[7:0];
  // write strobes, one per register; they land at the end of the answer
  wire         wr_hc    = wr & sel_hc;
  wire         wr_lc    = wr & sel_lc;
  wire         wr_he    = wr & sel_he;
  wire         wr_le    = wr & sel_le;
  wire         wr_bo    = wr & sel_bo & bop_le;
  wire         wr_en    = wr & sel_en;
  // one-bit update of a register byte
  function automatic logic [7:0] bit_update(input logic [7:0] v,
                                            input logic [2:0] b,
                                            input logic       s);
    logic [7:0] r;
    r    = v;
    r[b] = s;
    return r;
  endfunction
  // bit-op to any other target is ignored, only ext low is bit addressable
  wire [7:0] low_ext_bop = bit_update(low_ext_q, bop_bit, bop_val);
  // read select; reserved bits show what was stored, unmapped reads zero
  always_comb
  begin
    if (sel_hc)
      rd_mux = {24'h0, high_core_q};
    else if (sel_he)
      rd_mux = {24'h0, high_ext_q};
    else if (sel_le)
      rd_mux = {24'h0, low_ext_q};
    else if (sel_lc)
      rd_mux = {24'h0, low_core_q};
    else if (sel_en)
      rd_mux = {21'h0, enable_q};
    else if (sel_pd)
      rd_mux = {21'h0, irq_req};
    else if (sel_sv)
      rd_mux = {27'h0, service_q};
    else
      rd_mux = irq_prio_pkg::UNMAPPED_READ;
  end
  // fixed one-wait-state slave: idle -> ack -> done
  // the done cycle keeps a request still held from being taken twice
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      irq_prio_pkg::ST_IDLE: if (access) state_d = irq_prio_pkg::ST_ACK;
      irq_prio_pkg::ST_ACK:  state_d = irq_prio_pkg::ST_DONE;
      irq_prio_pkg::ST_DONE: state_d = irq_prio_pkg::ST_IDLE;
      default:               state_d = irq_prio_pkg::ST_IDLE;
    endcase
  end
  assign avs_waitrequest = !take;
  assign avs_readdata    = rdata_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= irq_prio_pkg::ST_IDLE;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      // loaded as the request is taken, so the data stand in the answer
      if (start)
        rdata_q <= rd_mux;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_core_q <= irq_prio_pkg::RESET_ZERO;
      low_core_q  <= irq_prio_pkg::RESET_ZERO;
      high_ext_q  <= irq_prio_pkg::RESET_ZERO;
      low_ext_q   <= irq_prio_pkg::RESET_ZERO;
      enable_q    <= '0;
    end
    else
    begin
      // ext low takes a whole byte or a single bit, never both at once
      if (wr_hc)
        high_core_q <= wbyte;
      if (wr_lc)
        low_core_q  <= wbyte;
      if (wr_he)
        high_ext_q  <= wbyte;
      if (wr_le)
        low_ext_q   <= wbyte;
      else if (wr_bo)
        low_ext_q   <= low_ext_bop;
      if (wr_en)
        enable_q    <= avs_writedata[NUM_SRC-1:0];
    end
  end
  // two-bit level of one source: msb from the high, lsb from the low reg
  function automatic logic [1:0] pair(input logic [7:0] hi,
                                      input logic [7:0] lo,
                                      input int         pos);
    return {hi[pos], lo[pos]};
  endfunction
  // per-source levels; core bit order differs from the polling order
  wire [1:0]   lv_ext0  =
    pair(high_core_q, low_core_q, irq_prio_pkg::POS_EXT0);
  wire [1:0]   lv_t0    =
    pair(high_core_q, low_core_q, irq_prio_pkg::POS_T0);
  wire [1:0]   lv_ext1  =
    pair(high_core_q, low_core_q, irq_prio_pkg::POS_EXT1);
  wire [1:0]   lv_t1    =
    pair(high_core_q, low_core_q, irq_prio_pkg::POS_T1);
  wire [1:0]   lv_pca   =
    pair(high_core_q, low_core_q, irq_prio_pkg::POS_PCA);
  wire [1:0]   lv_uart  =
    pair(high_core_q, low_core_q, irq_prio_pkg::POS_UART);
  wire [1:0]   lv_t2    =
    pair(high_core_q, low_core_q, irq_prio_pkg::POS_T2);
  wire [1:0]   lv_can   =
    pair(high_ext_q, low_ext_q, irq_prio_pkg::POS_CAN);
  wire [1:0]   lv_adc   =
    pair(high_ext_q, low_ext_q, irq_prio_pkg::POS_ADC);
  wire [1:0]   lv_tovr  =
    pair(high_ext_q, low_ext_q, irq_prio_pkg::POS_TIMOVR);
  wire [1:0]   lv_spi   =
    pair(high_ext_q, low_ext_q, irq_prio_pkg::POS_SPI);
  // packed in polling order, ext0 in the lowest pair
  assign levels = {lv_spi, lv_tovr, lv_adc, lv_can, lv_t2, lv_uart,
                   lv_pca, lv_t1, lv_ext1, lv_t0, lv_ext0};
  // keep all bits but the highest set one
  function automatic logic [4:0] top_mask(input logic [4:0] v);
    logic [4:0] m;
    m = 5'h1F;
    for (int k = 0; k < 5; k++)
      if (v[k])
        m = 5'h1F ^ (5'h01 << k);
    return m;
  endfunction
  // nested service stack, one bit per level; return clears the top one
  // an entry and a return in one cycle keep the entry: the core never
  // issues both, so the lost return only matters to a broken core
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      service_q <= 5'h00;
    else if (irq_ack && irq_valid)
      service_q <= service_q | (5'h02 << irq_level);
    else if (irq_return)
      service_q <= service_q & top_mask(service_q);
  end
  // requests are masked by their enables before they compete
  irq_prio_arbiter #(
    .N (NUM_SRC)
  ) u_arb (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .req         (irq_req & enable_q),
    .level       (levels),
    .in_service  (service_q),
    .win_valid_q (irq_valid),
    .win_src_q   (irq_src),
    .win_level_q (irq_level)
  );
endmodule

/* testbench/irq_prio_regs_assertions.sv */
`timescale 1ns/100ps
module irq_prio_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // core side
  input wire logic        irq_ack,
  input wire logic        irq_return,
  input wire logic        irq_valid,
  input wire logic [3:0]  irq_src,
  input wire logic [1:0]  irq_level
);
  logic [7:0] hc_q, lc_q, he_q, le_q;
  wire        wr = avs_write && !avs_waitrequest;
  wire        rd = avs_read && !avs_waitrequest;
  wire [7:0]  a = avs_address;
  wire [7:0]  d = avs_writedata[7:0];
  // shadow copies; bit writes via the bit-op port land in le_q
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      {hc_q, lc_q, he_q, le_q} <= 32'h0;
    else if (wr && a == 8'hB7)
      hc_q <= d;
    else if (wr && a == 8'hB8)
      lc_q <= d;
    else if (wr && a == 8'hF7)
      he_q <= d;
    else if (wr && a == 8'hF8)
      le_q <= d;
    else if (wr && a == 8'hCC && d == 8'hF8)
      le_q[avs_writedata[10:8]] <= avs_writedata[15];
  function automatic logic [1:0] lvl(input logic [3:0] s);
    logic [2:0] p;
    p = (s == 4'h4) ? 3'h6 : (s == 4'h5) ? 3'h4 : (s == 4'h6) ? 3'h5 : s[2:0];
    lvl = (s < 4'h7) ? {hc_q[p], lc_q[p]} : {he_q[s-7], le_q[s-7]};
  endfunction
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence ack_held;
    irq_ack ##1 !irq_return [*2];
  endsequence
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  answer_bound_a: assert property
    ($rose(avs_read || avs_write) |-> ##[1:3] !avs_waitrequest)
    else $error("bus access not answered in time");
  read_hc_a: assert property
    (rd && a == 8'hB7 |-> avs_readdata == hc_q)
    else $error("core high register read wrong");
  read_he_a: assert property
    (rd && a == 8'hF7 |-> avs_readdata == he_q)
    else $error("ext high register read wrong");
  read_le_a: assert property
    (rd && a == 8'hF8 |-> avs_readdata == le_q)
    else $error("ext low register read wrong");
  unmapped_a: assert property (rd && a == 8'h10 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  src_range_a: assert property (irq_valid |-> irq_src < 4'hB)
    else $error("winner index out of range");
  level_match_a: assert property
    (irq_valid && !$past(wr) |-> irq_level == lvl(irq_src))
    else $error("winner level does not match registers");
  preempt_only_a: assert property
    (ack_held |-> !irq_valid || irq_level > $past(irq_level, 2))
    else $error("request at or below serviced level offered");
endmodule

/* testbench/irq_src_model.sv */
`timescale 1ns/100ps
module irq_src_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // one-cycle source events from the bench
  input  wire logic [10:0] raise,
  // core handshake
  input  wire logic        irq_ack,
  input  wire logic [3:0]  irq_src,
  // level requests
  output logic      [10:0] irq_req
);
  // a source keeps asking until its handler is entered
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      irq_req <= 11'h0;
    else
      irq_req <= (irq_req | raise) & ~(irq_ack ? 11'h1 << irq_src : 11'h0);
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  avs_address = 8'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, irq_valid;
  logic [10:0] irq_req;
  logic [10:0] raise = 11'h0;
  logic        irq_ack = 1'h0;
  logic        irq_return = 1'h0;
  logic [3:0]  irq_src;
  logic [1:0]  irq_level;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  always #2 core_clk = ~core_clk;
  irq_prio_regs i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_req(irq_req),
    .irq_ack(irq_ack), .irq_return(irq_return), .irq_valid(irq_valid),
    .irq_src(irq_src), .irq_level(irq_level));
  irq_src_model i_src (.core_clk(core_clk), .rst_n(rst_n), .raise(raise),
    .irq_ack(irq_ack), .irq_src(irq_src), .irq_req(irq_req));
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, tests need a few hundred cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_errors++;
      summarize;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low, then an idle edge
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    bus(1'h0, ad, 32'h0);
    chk(q, exp);
  endtask
  task automatic take(input logic [3:0] s, input logic [1:0] l);
    do @(posedge core_clk); while (irq_valid !== 1'h1);
    chk(irq_src, s);
    chk(irq_level, l);
    irq_ack <= 1'h1;
    @(posedge core_clk);
    irq_ack <= 1'h0;
  endtask
  task automatic ret;
    irq_return <= 1'h1;
    @(posedge core_clk);
    irq_return <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic fire(input logic [10:0] b);
    raise <= b;
    @(posedge core_clk);
    raise <= 11'h0;
  endtask
  logic [7:0] ads [3] = '{8'hB7, 8'hF7, 8'hF8};
  logic [7:0] pat [3] = '{8'h55, 8'h0A, 8'h01};
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    foreach (ads[i]) rd(ads[i], 32'h0);
    rd(8'h10, 32'h0);
    foreach (ads[i])
    begin
      bus(1'h1, ads[i], {24'h0, pat[i]});
      rd(ads[i], {24'h0, pat[i]});
    end
    bus(1'h1, 8'hCC, 32'h82F8);
    rd(8'hF8, 32'h5);
    bus(1'h1, 8'hCC, 32'h00F8);
    rd(8'hF8, 32'h4);
    bus(1'h1, 8'hCC, 32'h81F7);
    rd(8'hF7, 32'hA);
    $display("register tests done");
    bus(1'h1, 8'hC4, 32'h7FF);
    bus(1'h1, 8'hB7, 32'h0);
    bus(1'h1, 8'hF7, 32'hC);
    bus(1'h1, 8'hF8, 32'h9);
    fire(11'h041);
    take(4'h0, 2'h0);
    ret;
    take(4'h6, 2'h0);
    ret;
    fire(11'h681);
    take(4'hA, 2'h3);
    ret;
    take(4'h9, 2'h2);
    ret;
    take(4'h7, 2'h1);
    ret;
    take(4'h0, 2'h0);
    ret;
    bus(1'h1, 8'hB8, 32'h2);
    fire(11'h003);
    take(4'h1, 2'h1);
    ret;
    take(4'h0, 2'h0);
    ret;
    bus(1'h1, 8'hC4, 32'h3FF);
    fire(11'h400);
    repeat (4) @(posedge core_clk);
    chk(irq_valid, 1'h0);
    rd(8'hC0, 32'h400);
    bus(1'h1, 8'hC4, 32'h7FF);
    take(4'hA, 2'h3);
    ret;
    bus(1'h1, 8'hB8, 32'h0);
    $display("arbitration tests done");
    fire(11'h001);
    take(4'h0, 2'h0);
    fire(11'h400);
    take(4'hA, 2'h3);
    fire(11'h002);
    repeat (6) @(posedge core_clk);
    chk(irq_valid, 1'h0);
    rd(8'hC8, 32'h12);
    rd(8'hC0, 32'h2);
    ret;
    chk(irq_valid, 1'h0);
    ret;
    take(4'h1, 2'h0);
    ret;
    $display("preemption tests done");
    summarize;
  end
endmodule
bind irq_prio_regs irq_prio_chk i_chk (
  .core_clk        (core_clk),
  .rst_n           (rst_n),
  .avs_address     (avs_address),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_writedata   (avs_writedata),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .irq_ack         (irq_ack),
  .irq_return      (irq_return),
  .irq_valid       (irq_valid),
  .irq_src         (irq_src),
  .irq_level       (irq_level)
);
